// File: pad_dimmer_map.vh
// pad_dimmer_map.vh: constants for the phase-angle dimmer scheduler
// assumes a 40 MHz system clock
`ifndef PAD_DIMMER_MAP_VH
`define PAD_DIMMER_MAP_VH

// ----------------------------------------
// channel layout
// ----------------------------------------
`define PAD_NUM_CH 12
`define PAD_CH_IDX_W 4
`define PAD_VAL_W 8
`define PAD_FIRST_OUT 5
`define PAD_RELAY_CH 4

// ----------------------------------------
// timing
// ----------------------------------------
`define PAD_CLK_HZ 40000000
`define PAD_TICK_NS 53000
`define PAD_CLK_NS 25
`define PAD_TICK_CYC 2120
`define PAD_PULSE_NS 10000
`define PAD_PULSE_CYC 400
`define PAD_TICK_W 12
`define PAD_PULSE_W 9

// ----------------------------------------
// system setting codes
// ----------------------------------------
`define PAD_SYS_ZC_CODE 8'h16
`define PAD_SYS_ZC_ON 8'h01
`define PAD_SYS_ZC_OFF 8'h00

// ----------------------------------------
// output modes per channel
// ----------------------------------------
`define PAD_MODE_OFF 2'h0
`define PAD_MODE_DIM 2'h1
`define PAD_MODE_ON 2'h2

`endif

// File: pad_zc_sync.v
// pad_zc_sync.v: two-stage synchroniser plus falling-edge detect
// assumes the input arrives from outside the clock domain
`timescale 1ns/1ps

module pad_zc_sync (
   input wire i_clk,
   input wire i_reset_n,
   input wire i_async,
   output wire o_fall
);

   reg meta_r;
   reg sync_r;
   reg prev_r;

   // ----------------------------------------
   // two flops, then a history flop
   // ----------------------------------------
   always @(posedge i_clk) begin
      if (!i_reset_n) begin
         meta_r <= 1'b1;
         sync_r <= 1'b1;
         prev_r <= 1'b1;
      end else begin
         meta_r <= i_async;
         sync_r <= meta_r;
         prev_r <= sync_r;
      end
   end

   // high for one cycle on a falling edge
   assign o_fall = prev_r & ~sync_r;

endmodule // pad_zc_sync

// File: pad_dimmer.v
// pad_dimmer.v: twelve-channel phase-angle dimmer scheduler
// assumes zero-crossing comes from an opto-isolator on a pin,
// and the command port is driven by logic on i_clk
`timescale 1ns/1ps
`include "pad_dimmer_map.vh"

module pad_dimmer #(
   parameter NUM_CH = `PAD_NUM_CH,
   parameter TICK_CYC = `PAD_TICK_CYC,
   parameter PULSE_CYC = `PAD_PULSE_CYC,
   parameter RELAY_VARIANT = 1'b0
) (
   input wire i_clk,
   input wire i_reset_n,
   input wire i_zero_cross,
   input wire i_sys_valid,
   input wire [7:0] i_sys_code,
   input wire [7:0] i_sys_arg,
   input wire i_dim_valid,
   input wire [`PAD_CH_IDX_W-1:0] i_dimmer_channel_index,
   input wire [`PAD_VAL_W-1:0] i_dim_value,
   input wire i_force_valid,
   input wire [`PAD_CH_IDX_W-1:0] i_force_channel,
   input wire [1:0] i_force_mode,
   output wire o_cmd_ready,
   output reg [16:5] o_dout,
   output reg o_zc_enabled,
   output reg o_zc_event,
   output reg o_cmd_error
);

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   // channel index 1..N maps to array slot 0..N-1; 0 when out of range
   function ch_ok;
      input [`PAD_CH_IDX_W-1:0] ch;
      input relay;
      begin
         ch_ok = (ch != {`PAD_CH_IDX_W{1'b0}}) && (ch <= NUM_CH) &&
                 (!relay || ch <= `PAD_RELAY_CH);
      end
   endfunction

   localparam [`PAD_TICK_W-1:0] TICK_LAST = TICK_CYC - 1;
   // load the full count so the output stands PULSE_CYC cycles
   localparam [`PAD_PULSE_W-1:0] PULSE_LOAD = PULSE_CYC;

   wire zc_fall;
   reg [`PAD_TICK_W-1:0] tick_cnt_r;
   reg [`PAD_VAL_W-1:0] tick_num_r;
   reg tick_sat_r;
   reg [`PAD_VAL_W-1:0] value_r [0:NUM_CH-1];
   reg [1:0] mode_r [0:NUM_CH-1];
   reg [NUM_CH-1:0] fired_r;
   reg [`PAD_PULSE_W-1:0] pulse_cnt_r [0:NUM_CH-1];
   reg running_r;
   integer k;

   assign o_cmd_ready = 1'b1;

   // ----------------------------------------
   // zero-crossing pin, synchronised
   // ----------------------------------------
   // the pin feeds only this detector, nothing else reads it
   pad_zc_sync u_zc (
      .i_clk(i_clk),
      .i_reset_n(i_reset_n),
      .i_async(i_zero_cross),
      .o_fall(zc_fall)
   );

   // ----------------------------------------
   // system setting and enable
   // ----------------------------------------
   always @(posedge i_clk) begin
      if (!i_reset_n) begin
         o_zc_enabled <= 1'b0;
         o_zc_event <= 1'b0;
      end else begin
         if (i_sys_valid && i_sys_code == `PAD_SYS_ZC_CODE) begin
            if (i_sys_arg == `PAD_SYS_ZC_ON)
               o_zc_enabled <= 1'b1;
            else if (i_sys_arg == `PAD_SYS_ZC_OFF)
               o_zc_enabled <= 1'b0;
         end
         o_zc_event <= zc_fall & o_zc_enabled;
      end
   end

   // ----------------------------------------
   // tick timebase restarted at each crossing
   // ----------------------------------------
   always @(posedge i_clk) begin
      if (!i_reset_n) begin
         tick_cnt_r <= {`PAD_TICK_W{1'b0}};
         tick_num_r <= {`PAD_VAL_W{1'b0}};
         tick_sat_r <= 1'b0;
         running_r <= 1'b0;
      end else if (zc_fall && o_zc_enabled) begin
         tick_cnt_r <= {`PAD_TICK_W{1'b0}};
         tick_num_r <= {`PAD_VAL_W{1'b0}};
         tick_sat_r <= 1'b0;
         running_r <= 1'b1;
      end else if (!o_zc_enabled) begin
         running_r <= 1'b0;
      end else if (running_r) begin
         if (tick_cnt_r == TICK_LAST) begin
            tick_cnt_r <= {`PAD_TICK_W{1'b0}};
            // count whole ticks since crossing, stop at the top
            if (tick_num_r == {`PAD_VAL_W{1'b1}})
               tick_sat_r <= 1'b1;
            else
               tick_num_r <= tick_num_r + 1'b1;
         end else begin
            tick_cnt_r <= tick_cnt_r + 1'b1;
         end
      end
   end

   // ----------------------------------------
   // per-channel values, modes and firing
   // ----------------------------------------
   always @(posedge i_clk) begin
      if (!i_reset_n) begin
         fired_r <= {NUM_CH{1'b0}};
         o_cmd_error <= 1'b0;
         for (k = 0; k < NUM_CH; k = k + 1) begin
            value_r[k] <= {`PAD_VAL_W{1'b0}};
            mode_r[k] <= `PAD_MODE_OFF;
            pulse_cnt_r[k] <= {`PAD_PULSE_W{1'b0}};
         end
      end else begin
         o_cmd_error <= 1'b0;
         // dimmer program command: held until rewritten
         if (i_dim_valid) begin
            if (ch_ok(i_dimmer_channel_index, RELAY_VARIANT) &&
                i_dim_value != {`PAD_VAL_W{1'b0}}) begin
               value_r[i_dimmer_channel_index - 1'b1] <= i_dim_value;
               mode_r[i_dimmer_channel_index - 1'b1] <= `PAD_MODE_DIM;
            end else begin
               o_cmd_error <= 1'b1;
            end
         end
         // forced level overrides dimming on that channel
         if (i_force_valid) begin
            if (i_force_channel != {`PAD_CH_IDX_W{1'b0}} && i_force_channel <= NUM_CH)
               mode_r[i_force_channel - 1'b1] <= i_force_mode;
            else
               o_cmd_error <= 1'b1;
         end
         for (k = 0; k < NUM_CH; k = k + 1) begin
            if (zc_fall && o_zc_enabled) begin
               fired_r[k] <= 1'b0; // re-arm each half cycle
            end else if (running_r && !fired_r[k] && !tick_sat_r &&
                         mode_r[k] == `PAD_MODE_DIM &&
                         tick_num_r + 1'b1 == value_r[k] &&
                         tick_cnt_r == TICK_LAST) begin
               // value one fires at end of first tick
               fired_r[k] <= 1'b1;
               pulse_cnt_r[k] <= PULSE_LOAD;
            end else if (pulse_cnt_r[k] != {`PAD_PULSE_W{1'b0}}) begin
               pulse_cnt_r[k] <= pulse_cnt_r[k] - 1'b1;
            end
         end
      end
   end

   // ----------------------------------------
   // output drive, channel n on output n+4
   // ----------------------------------------
   always @(posedge i_clk) begin
      if (!i_reset_n) begin
         o_dout <= 12'h000;
      end else begin
         for (k = 0; k < NUM_CH; k = k + 1) begin
            case (mode_r[k])
               `PAD_MODE_ON: o_dout[k + `PAD_FIRST_OUT] <= 1'b1;
               `PAD_MODE_DIM: o_dout[k + `PAD_FIRST_OUT] <=
                  o_zc_enabled && (pulse_cnt_r[k] != {`PAD_PULSE_W{1'b0}});
               default: o_dout[k + `PAD_FIRST_OUT] <= 1'b0;
            endcase
         end
      end
   end

endmodule // pad_dimmer

// File: pad_zc_src.sv
// pad_zc_src.sv: opto zero-crossing detector model
// assumes the bench clock; HALF is one mains half cycle in clocks
`timescale 1ns/1ps
module pad_zc_src #(parameter HALF = 64) (
   input wire logic i_clk,
   input wire logic i_run,
   output logic o_zc = 1'b1
);
   int cnt = 0;
   // output dips low for two clocks at each crossing
   always @(posedge i_clk) begin
      cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
      o_zc <= #1 !(i_run && cnt < 2);
   end
endmodule // pad_zc_src

// File: pad_dimmer_properties.sv
// pad_dimmer_properties.sv: port checks for the dimmer
// assumes one clock domain and synchronous reset
`timescale 1ns/1ps
module pad_dimmer_properties (
   input logic i_clk, i_reset_n, i_zero_cross, i_sys_valid,
   input logic [7:0] i_sys_code, i_sys_arg,
   input logic i_dim_valid,
   input logic [3:0] i_dimmer_channel_index,
   input logic [7:0] i_dim_value,
   input logic i_force_valid,
   input logic [3:0] i_force_channel,
   input logic [1:0] i_force_mode,
   input logic o_cmd_ready,
   input logic [16:5] o_dout,
   input logic o_zc_enabled, o_zc_event, o_cmd_error
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);
   // zero-cross enable command with a chosen argument
   sequence zc_cmd_s(a);
      i_sys_valid && i_sys_code == 8'h16 && i_sys_arg == a;
   endsequence
   sequence frc_s(m);
      i_force_valid && i_force_channel == 4'h3 && i_force_mode == m;
   endsequence
   zc_enable_a: assert property (zc_cmd_s(8'h01) |=> o_zc_enabled)
      else $error("enable lost");
   zc_disable_a: assert property (zc_cmd_s(8'h00) |=> !o_zc_enabled)
      else $error("disable lost");
   zc_event_a: assert property (o_zc_enabled && $fell(i_zero_cross) |-> ##[2:4] o_zc_event)
      else $error("crossing missed");
   bad_ch_a: assert property (i_dim_valid && (i_dimmer_channel_index == 4'h0 ||
      i_dimmer_channel_index > 4'hc) |=> o_cmd_error) else $error("bad channel taken");
   zero_val_a: assert property (i_dim_valid && i_dim_value == 8'h00 |=> o_cmd_error)
      else $error("zero value taken");
   good_cmd_a: assert property (i_dim_valid && !i_force_valid && i_dim_value != 8'h00 &&
      i_dimmer_channel_index inside {[1:12]} |=> !o_cmd_error) else $error("good cmd refused");
   force_on_a: assert property (frc_s(2'h2) |-> ##2 o_dout[7])
      else $error("force on lost");
   force_off_a: assert property (frc_s(2'h0) |-> ##2 !o_dout[7])
      else $error("force off lost");
endmodule // pad_dimmer_properties
bind pad_dimmer pad_dimmer_properties chk_i (.*);

// File: phase_angle_dimmer_test.sv
// phase_angle_dimmer_test.sv: directed bench for the dimmer
// assumes short tick and pulse parameters to keep the run brief
`timescale 1ns/1ps
module phase_angle_dimmer_test;
   localparam int T = 8;
   localparam int P = 3;
   logic i_clk = 0, i_reset_n = 0, run = 0, zc, sv = 0, dv = 0, fv = 0, s6 = 0;
   logic [7:0] arg = 0, val = 0;
   logic [3:0] ch = 0, fch = 0;
   logic [1:0] mode = 0;
   logic rdy, en, ev, er, de;
   logic [16:5] dout;
   int err_count = 0, compares = 0, cyc = 0, t1, t2, t3, te, w;
   pad_zc_src #(.HALF(64)) zsrc (.i_clk(i_clk), .i_run(run), .o_zc(zc));
   pad_dimmer #(.TICK_CYC(T), .PULSE_CYC(P)) dut (.i_clk(i_clk), .i_reset_n(i_reset_n),
      .i_zero_cross(zc), .i_sys_valid(sv), .i_sys_code(8'h16), .i_sys_arg(arg),
      .i_dim_valid(dv), .i_dimmer_channel_index(ch), .i_dim_value(val),
      .i_force_valid(fv), .i_force_channel(fch), .i_force_mode(mode),
      .o_cmd_ready(rdy), .o_dout(dout), .o_zc_enabled(en), .o_zc_event(ev),
      .o_cmd_error(er));
   initial forever #12.5 i_clk = ~i_clk;
   // cycle count and sticky watch on an unprogrammed channel
   always @(posedge i_clk) begin
      cyc <= cyc + 1;
      s6 <= s6 | (i_reset_n & dout[6]);
   end
   task conclude;
      $display("errors %0d compares %0d", err_count, compares);
      if (err_count == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task chk(input string n, input logic [31:0] e, s);
      compares++;
      if (s !== e) begin
         err_count++;
         $display("MISMATCH %s exp %0h got %0h", n, e, s);
      end
   endtask
   task tk;
      @(posedge i_clk) #1;
   endtask
   task sys(input logic [7:0] a);
      arg = a; sv = 1; tk; sv = 0; tk;
   endtask
   task dim(input logic [3:0] k, input logic [7:0] v);
      ch = k; val = v; dv = 1; tk; dv = 0; de = er; tk;
   endtask
   task frc(input logic [3:0] k, input logic [1:0] m);
      fch = k; mode = m; fv = 1; tk; fv = 0; tk;
   endtask
   task rise(input int b, output int t);
      for (w = 0; w < 200 && dout[b] !== 1'b1; w++) tk;
      t = cyc;
   endtask
   task t_off;
      dim(1, 1); frc(1, 1); frc(2, 1); run = 1;
      for (w = 0; w < 140; w++) begin
         if (dout[5] !== 1'b0) t1 = 1;
         tk;
      end
      chk("dout5 disabled", 0, t1);
   endtask
   task t_dim;
      sys(1); chk("enabled", 1, en);
      dim(12, 3); frc(12, 1);
      for (w = 0; w < 100 && ev !== 1'b1; w++) tk;
      te = cyc; rise(5, t1); rise(16, t2);
      chk("ch12 gap", 2 * T, t2 - t1);
      chk("value one early", 1, t1 - te <= T + 2);
      for (w = 0; dout[16] === 1'b1 && w < 50; w++) tk;
      chk("pulse width", P, w);
      rise(5, t3); chk("period", 64, t3 - t1);
      sys(0); chk("disabled", 0, en);
      chk("unprogrammed ch2", 0, s6);
   endtask
   task t_err;
      dim(0, 5); chk("err ch0", 1, de);
      dim(13, 5); chk("err ch13", 1, de);
      dim(1, 0); chk("err zero", 1, de);
      chk("ready", 1, rdy);
   endtask
   task t_force;
      frc(3, 2); chk("forced on", 1, dout[7]);
      repeat (100) tk;
      chk("still on", 1, dout[7]);
      frc(3, 0); chk("forced off", 0, dout[7]);
   endtask
   initial begin
      t1 = 0;
      repeat (2) @(posedge i_clk);
      #1 i_reset_n = 1;
      t_off; t_dim; t_err; t_force;
      conclude;
   end
   initial begin
      repeat (3000) @(posedge i_clk);
      err_count++;
      conclude;
   end
endmodule // phase_angle_dimmer_test
